// ### itc_asserts.sv
// Checker for itc_top port timing.
// Assumes a bind from the bench; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module itc_asserts #(
  parameter int NUM_CH = 3
) (
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic              chip_sel_n_i,
  input wire logic              rd_n_i,
  input wire logic              wr_n_i,
  input wire logic              port_select_hi_i,
  input wire logic              port_select_lo_i,
  input wire logic [7:0]        data_i,
  input wire logic [NUM_CH-1:0] tick_i,
  input wire logic [7:0]        data_o,
  input wire logic              data_oe_o,
  input wire logic [NUM_CH-1:0] out_level_o
);
  // Read strobe qualified by select, control address
  logic rd_on;
  logic ctl;
  assign rd_on = !chip_sel_n_i && !rd_n_i;
  assign ctl   = port_select_hi_i && port_select_lo_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  rd_ctl_quiet_a: assert property (rd_on && ctl |=> !data_oe_o)
    else $error("driver on during control read");
  rd_chan_drive_a: assert property (rd_on && !ctl |=> data_oe_o)
    else $error("driver off during channel read");
  oe_cause_a: assert property (data_oe_o |-> $past(rd_on) && !$past(ctl))
    else $error("driver on without channel read");
  data_hold_a: assert property ($changed(data_o) |-> $past(rd_on) || $past(rd_on, 2))
    else $error("read data moved without a read");
  wr_quiet_a: assert property (!chip_sel_n_i && !wr_n_i && rd_n_i |=> !data_oe_o)
    else $error("driver on during write");
  oe_desel_a: assert property ($past(chip_sel_n_i) |-> !data_oe_o)
    else $error("driver on while deselected");
  out_tick_a: assert property (
    (out_level_o & ~$past(out_level_o) & ~($past(tick_i) | $past(tick_i, 2))) == '0)
    else $error("output rose without a tick");
  rst_quiet_a: assert property ($rose(rst_n_i) |-> data_o == 8'h00 && !data_oe_o)
    else $error("outputs not idle after reset");
  // Main traffic seen
  cover property (rd_on && !ctl ##2 data_oe_o);
  cover property (!chip_sel_n_i && !wr_n_i && ctl);
  cover property ($changed(data_o));
endmodule : itc_asserts
`default_nettype wire

// ### itc_channel_stage.sv
// One channel's counting element stand-in: loads the preload on a tick.
// Assumes load requests from the bus side and a one-cycle tick enable.
`timescale 1ns/1ps
`default_nettype none
module itc_channel_stage (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        tick_i,
  input  wire logic        load_req_i,
  input  wire logic [15:0] preload_i,
  output logic      [15:0] count_o,
  output logic             loaded_o,
  output logic             out_level_o
);

  // ****************************************************************
  // Counting element
  // ****************************************************************
  // Load happens on a tick; the tick itself does not decrement
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_o     <= 16'h0000;
      loaded_o    <= 1'b0;
      out_level_o <= 1'b0;
    end else begin
      loaded_o <= 1'b0;
      if (tick_i) begin
        if (load_req_i) begin
          count_o  <= preload_i;
          loaded_o <= 1'b1;
        end else begin
          count_o <= count_o - 16'h0001;
        end
        out_level_o <= (count_o == 16'h0001);
      end
    end
  end

endmodule : itc_channel_stage
`default_nettype wire

// ### itc_host_model.sv
// Host CPU model driving the timer's 8-bit bus.
// Assumes it shares clk_i with the timer.
`timescale 1ns/1ps
`default_nettype none
module itc_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdat_i,
  input  wire logic       roe_i,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic [1:0]      adr_o,
  output logic [7:0]      wdat_o
);
  // Bus idle at time zero
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    adr_o  = 2'h0;
    wdat_o = 8'h5a;
  end
  // One whole write; data flips after release so stale bytes never look valid
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    adr_o  <= a;
    wdat_o <= d;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    wdat_o <= ~d;
  endtask : wr
  // One read; byte and enable taken at the edge, then the strobe lets go
  task automatic rd(input logic [1:0] a, output logic [7:0] d, output logic oe);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    adr_o  <= a;
    @(posedge clk_i);
    @(posedge clk_i);
    d  = rdat_i;
    oe = roe_i;
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
  endtask : rd
endmodule : itc_host_model
`default_nettype wire

// ### itc_pkg.sv
// Package for the interval timer count programming and readback block.
// Assumes one 100 MHz clock; bus strobes are sampled synchronously.
package itc_pkg;

  // ****************************************************************
  // Addresses and command fields
  // ****************************************************************
  localparam logic [1:0] ADDR_CONTROL_PORT = 2'h3;   // control_command_port
  localparam int         NUM_CHANNELS      = 3;
  localparam int         CMD_PICK_HI       = 7;      // channel_pick_hi
  localparam int         CMD_PICK_LO       = 6;      // channel_pick_lo
  localparam int         CMD_ORDER_HI      = 5;      // byte_order_hi
  localparam int         CMD_ORDER_LO      = 4;      // byte_order_lo
  localparam int         RB_COUNT_N        = 5;      // Low latches count
  localparam int         RB_STATUS_N       = 4;      // Low latches status
  localparam int         RB_PICK_TWO       = 3;      // pick_channel_two
  localparam int         RB_PICK_ONE       = 2;      // pick_channel_one
  localparam int         RB_PICK_ZERO      = 1;      // pick_channel_zero
  localparam logic [1:0] PICK_READBACK     = 2'h3;
  localparam int         STAT_OUT_BIT      = 7;
  localparam int         STAT_PEND_BIT     = 6;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ITC_FMT_LATCH,
    ITC_FMT_LOW,
    ITC_FMT_HIGH,
    ITC_FMT_BOTH
  } itc_fmt_e;

  // Per channel bookkeeping
  typedef struct packed {
    logic [5:0]  mode_fields;   // Bits 5:0 of the last control word
    logic [15:0] preload;       // preload_holding_reg
    logic [15:0] frozen;        // frozen_value_latch
    logic        count_held;
    logic [7:0]  status_byte;
    logic        status_held;
    logic        load_pending;
    logic        rd_second;     // Next read returns high byte
    logic        wr_second;     // Next write is high byte
    logic        load_armed;    // Whole count written, waits for a tick
  } itc_chan_s;

  typedef struct packed {
    itc_chan_s [NUM_CHANNELS-1:0] chan;
    logic      [7:0]              rd_data;
    logic                         rd_valid;
  } itc_state_s;

  localparam logic [7:0] RESET_STATUS = 8'h00;

endpackage : itc_pkg

// ### itc_top.sv
// Count programming and readback logic of a three channel interval timer.
// Assumes synchronous bus strobes and per-channel one-cycle tick enables.
// Assumes the host follows the programmed byte format and keeps two-byte
// transfers of one channel uninterrupted by other routines.
`timescale 1ns/1ps
`default_nettype none
module itc_top #(
  parameter int NUM_CH = itc_pkg::NUM_CHANNELS
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              chip_sel_n_i,
  input  wire logic              rd_n_i,
  input  wire logic              wr_n_i,
  input  wire logic              port_select_hi_i,
  input  wire logic              port_select_lo_i,
  input  wire logic [7:0]        data_i,
  input  wire logic [NUM_CH-1:0] tick_i,
  output logic      [7:0]        data_o,
  output logic                   data_oe_o,
  output logic      [NUM_CH-1:0] out_level_o
);

  // ****************************************************************
  // Bus behaviour in brief
  // ****************************************************************
  // A write is taken in the first cycle that chip select and the write
  // strobe are seen low together; a strobe held low counts only once.
  // A read is taken the same way; its byte shows one cycle later and
  // stays on data_o until the next channel read is taken.
  // Reads of the control port leave the driver off and data_o alone.
  // Reads and writes may be mixed across channels in any order, as long
  // as each channel gets its control word before its count bytes.
  // Each channel has its own read and write byte pointers, so a split
  // two-byte read may have writes of the same channel between its halves.
  // A control word for a channel drops its held count, its held status
  // and both pointers, and parks the load until a full count arrives;
  // a tick before then keeps counting down from the old value.
  // A latch command for a channel that already holds a count is ignored,
  // as is a status latch for a channel whose status is still unread.
  //
  // Status byte of a channel:
  //   bit 7     output level when the status was latched
  //   bit 6     load pending: control word or count written, count not yet in the counter
  //   bits 5:0  mode fields of the last control word, as written
  //
  // Output levels lag the counting elements by one clock, so software
  // polling out_level_o and the status bit may see them a cycle apart.
  // Limitations: the counting element is a plain down counter with no
  // modes, no gate and no decimal counting; writing the first byte of a
  // two-byte count does not stop counting. Writes to a channel that has
  // never been programmed are dropped.

  // ****************************************************************
  // Declarations
  // ****************************************************************
  itc_pkg::itc_state_s state_r;
  itc_pkg::itc_state_s state_nxt;
  logic [1:0]          addr;
  logic                rd_d_r;
  logic                wr_d_r;
  logic                rd_start;
  logic                wr_start;
  logic [NUM_CH-1:0]   load_req;
  logic [NUM_CH-1:0]   loaded;
  logic [NUM_CH-1:0]   ce_out;
  logic [15:0]         ce_count [NUM_CH];
  logic                oe_r;
  logic [NUM_CH-1:0]   out_r;

  // Two address lines pick a channel or the control port
  assign addr = {port_select_hi_i, port_select_lo_i};

  // Strobe edges, one access per strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_d_r <= 1'b0;
      wr_d_r <= 1'b0;
    end else begin
      rd_d_r <= !chip_sel_n_i && !rd_n_i;
      wr_d_r <= !chip_sel_n_i && !wr_n_i;
    end
  end

  // Start pulses last one cycle however long the strobe stays low
  assign rd_start = !chip_sel_n_i && !rd_n_i && !rd_d_r;
  assign wr_start = !chip_sel_n_i && !wr_n_i && !wr_d_r;

  // ****************************************************************
  // Counting elements
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      // Load only once a whole count is in; pending alone is not enough
      assign load_req[g] = state_r.chan[g].load_armed;
      itc_channel_stage u_stage (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .tick_i      (tick_i[g]),
        .load_req_i  (load_req[g]),
        .preload_i   (state_r.chan[g].preload),
        .count_o     (ce_count[g]),
        .loaded_o    (loaded[g]),
        .out_level_o (ce_out[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Command, write and read sequencing
  // ****************************************************************
  always_comb begin
    logic [15:0]       live;
    logic [1:0]        fmt;
    logic [NUM_CH-1:0] pick;
    int                ci;
    live      = 16'h0000;
    fmt       = 2'h0;
    pick      = '0;
    ci        = 0;
    state_nxt = state_r;
    state_nxt.rd_valid = 1'b0;

    // Load completion clears pending; a new write below sets it again
    for (int i = 0; i < NUM_CH; i++) begin
      if (loaded[i]) begin
        state_nxt.chan[i].load_pending = 1'b0;
        state_nxt.chan[i].load_armed   = 1'b0;
      end
    end

    if (wr_start && addr == itc_pkg::ADDR_CONTROL_PORT) begin
      // Control address decode
      if (data_i[itc_pkg::CMD_PICK_HI:itc_pkg::CMD_PICK_LO] ==
          itc_pkg::PICK_READBACK) begin
        // Read-back: the reserved lowest bit is not looked at
        pick = {data_i[itc_pkg::RB_PICK_TWO], data_i[itc_pkg::RB_PICK_ONE],
                data_i[itc_pkg::RB_PICK_ZERO]};
        for (int i = 0; i < NUM_CH; i++) begin
          if (pick[i]) begin
            // Count latch half behaves as a latch command
            if (!data_i[itc_pkg::RB_COUNT_N] &&
                !state_r.chan[i].count_held) begin
              state_nxt.chan[i].count_held = 1'b1;
              state_nxt.chan[i].frozen     = ce_count[i];
            end
            // First status latch wins
            if (!data_i[itc_pkg::RB_STATUS_N] &&
                !state_r.chan[i].status_held) begin
              state_nxt.chan[i].status_held = 1'b1;
              state_nxt.chan[i].status_byte =
                {ce_out[i], state_r.chan[i].load_pending,
                 state_r.chan[i].mode_fields};
            end
          end
        end
      end else begin
        ci = int'(data_i[itc_pkg::CMD_PICK_HI:itc_pkg::CMD_PICK_LO]);
        if (data_i[itc_pkg::CMD_ORDER_HI:itc_pkg::CMD_ORDER_LO] ==
            2'(itc_pkg::ITC_FMT_LATCH)) begin
          // Latch without touching mode
          if (!state_r.chan[ci].count_held) begin
            state_nxt.chan[ci].count_held = 1'b1;
            state_nxt.chan[ci].frozen     = ce_count[ci];
          end
        end else begin
          // Reprogram: mode fields, pending, latches, pointers
          state_nxt.chan[ci].mode_fields  = data_i[5:0];
          state_nxt.chan[ci].load_pending = 1'b1;
          // No load until the new count is complete
          state_nxt.chan[ci].load_armed   = 1'b0;
          state_nxt.chan[ci].count_held   = 1'b0;
          state_nxt.chan[ci].status_held  = 1'b0;
          state_nxt.chan[ci].rd_second    = 1'b0;
          state_nxt.chan[ci].wr_second    = 1'b0;
        end
      end
    end else if (wr_start) begin
      // Count byte write; mode fields are never touched here
      ci  = int'(addr);
      fmt = state_r.chan[ci].mode_fields[5:4];
      case (fmt)
        2'(itc_pkg::ITC_FMT_LOW): begin
          state_nxt.chan[ci].preload      = {8'h00, data_i};
          state_nxt.chan[ci].load_pending = 1'b1;
          state_nxt.chan[ci].load_armed   = 1'b1;
        end
        2'(itc_pkg::ITC_FMT_HIGH): begin
          state_nxt.chan[ci].preload      = {data_i, 8'h00};
          state_nxt.chan[ci].load_pending = 1'b1;
          state_nxt.chan[ci].load_armed   = 1'b1;
        end
        2'(itc_pkg::ITC_FMT_BOTH): begin
          // Low byte first; the high byte completes the count
          if (!state_r.chan[ci].wr_second) begin
            state_nxt.chan[ci].preload[7:0] = data_i;
            state_nxt.chan[ci].wr_second    = 1'b1;
          end else begin
            state_nxt.chan[ci].preload[15:8] = data_i;
            state_nxt.chan[ci].wr_second     = 1'b0;
            state_nxt.chan[ci].load_pending  = 1'b1;
            state_nxt.chan[ci].load_armed    = 1'b1;
          end
        end
        default: begin
          // Unprogrammed channel: write ignored
        end
      endcase
    end

    if (rd_start && addr != itc_pkg::ADDR_CONTROL_PORT) begin
      ci   = int'(addr);
      fmt  = state_r.chan[ci].mode_fields[5:4];
      // Old count until the load happens
      live = state_r.chan[ci].count_held ? state_r.chan[ci].frozen
                                         : ce_count[ci];
      state_nxt.rd_valid = 1'b1;
      // A held status always goes out first, whatever was latched first
      if (state_r.chan[ci].status_held) begin
        state_nxt.rd_data             = state_r.chan[ci].status_byte;
        state_nxt.chan[ci].status_held = 1'b0;
      end else begin
        case (fmt)
          2'(itc_pkg::ITC_FMT_LOW): begin
            state_nxt.rd_data             = live[7:0];
            state_nxt.chan[ci].count_held = 1'b0;
          end
          2'(itc_pkg::ITC_FMT_HIGH): begin
            state_nxt.rd_data             = live[15:8];
            state_nxt.chan[ci].count_held = 1'b0;
          end
          2'(itc_pkg::ITC_FMT_BOTH): begin
            // Low byte first; the high byte also frees the held count
            if (!state_r.chan[ci].rd_second) begin
              state_nxt.rd_data             = live[7:0];
              state_nxt.chan[ci].rd_second  = 1'b1;
            end else begin
              state_nxt.rd_data             = live[15:8];
              state_nxt.chan[ci].rd_second  = 1'b0;
              state_nxt.chan[ci].count_held = 1'b0;
            end
          end
          default: begin
            state_nxt.rd_data = 8'h00;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // State register and outputs
  // ****************************************************************
  // Read data holds until the next channel read starts
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= '0;
      oe_r    <= 1'b0;
      out_r   <= '0;
    end else begin
      state_r <= state_nxt;
      oe_r    <= !chip_sel_n_i && !rd_n_i && addr != itc_pkg::ADDR_CONTROL_PORT;
      out_r   <= ce_out;
    end
  end

  // Read byte straight from the state register
  assign data_o      = state_r.rd_data;
  // Driver enable follows the read strobe on a channel address
  assign data_oe_o   = oe_r;
  // Output levels, one cycle behind the counting elements
  assign out_level_o = out_r;

endmodule : itc_top
`default_nettype wire

// ### itc_top_bench.sv
// Self-checking bench for itc_top with a host model.
// Assumes ticks stand still unless a scenario pulses them.
`timescale 1ns/1ps
`default_nettype none
module itc_top_bench;
  logic       clk_i;
  logic       rst_n_i;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic [1:0] adr;
  logic [7:0] wdat;
  logic [2:0] tick;
  logic [7:0] rdat;
  logic       oe;
  logic [2:0] out_lvl;
  logic [7:0] rv;
  logic       roe;
  int         errors = 0;
  int         num_checks = 0;
  int         cycles = 0;
  itc_top u_itc_top (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .chip_sel_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .port_select_hi_i(adr[1]), .port_select_lo_i(adr[0]),
    .data_i(wdat), .tick_i(tick), .data_o(rdat), .data_oe_o(oe), .out_level_o(out_lvl));
  itc_host_model u_itc_host_model (
    .clk_i(clk_i), .rdat_i(rdat), .roe_i(oe), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .adr_o(adr), .wdat_o(wdat));
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // Byte compare
  task automatic cb(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected byte at %0t: %h not %h", $time, got, exp);
    end
  endtask : cb
  // Bit compare
  task automatic cbit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected bit at %0t: %b not %b", $time, got, exp);
    end
  endtask : cbit
  // Channel read: byte and driver enable
  task automatic r(input logic [1:0] a, input logic [7:0] exp);
    u_itc_host_model.rd(a, rv, roe);
    cb(rv, exp);
    cbit(roe, 1'b1);
  endtask : r
  task automatic w(input logic [1:0] a, input logic [7:0] d);
    u_itc_host_model.wr(a, d);
  endtask : w
  // One count pulse on the chosen channels
  task automatic t(input logic [2:0] m);
    @(posedge clk_i);
    tick <= m;
    @(posedge clk_i);
    tick <= 3'h0;
  endtask : t
  // Channel 0: pending flag, old count before load, frozen count
  task automatic s_latch();
    w(2'h3, 8'h34);
    w(2'h3, 8'he2);
    r(2'h0, 8'h74);
    w(2'h0, 8'h10);
    w(2'h0, 8'h00);
    w(2'h3, 8'h00);
    r(2'h0, 8'h00);
    r(2'h0, 8'h00);
    t(3'h1);
    w(2'h3, 8'he2);
    r(2'h0, 8'h34);
    w(2'h3, 8'h00);
    t(3'h1);
    t(3'h1);
    w(2'h3, 8'h00);
    r(2'h0, 8'h10);
    r(2'h0, 8'h00);
    w(2'h3, 8'h00);
    r(2'h0, 8'h0e);
    r(2'h0, 8'h00);
  endtask : s_latch
  // Channels 1 and 2 interleaved, reads mixed with writes
  task automatic s_mix();
    w(2'h3, 8'h70);
    w(2'h3, 8'hb0);
    w(2'h2, 8'h22);
    w(2'h1, 8'h11);
    w(2'h1, 8'h01);
    w(2'h2, 8'h02);
    t(3'h6);
    w(2'h3, 8'h40);
    w(2'h3, 8'h80);
    r(2'h1, 8'h11);
    w(2'h1, 8'h33);
    r(2'h2, 8'h22);
    r(2'h1, 8'h01);
    w(2'h1, 8'h03);
    r(2'h2, 8'h02);
    w(2'h3, 8'he4);
    r(2'h1, 8'h70);
  endtask : s_mix
  // Read-back: status first, repeats ignored, selection by mask
  task automatic s_rback();
    t(3'h2);
    w(2'h3, 8'hc4);
    t(3'h2);
    w(2'h3, 8'he4);
    w(2'h3, 8'hc4);
    r(2'h1, 8'h30);
    r(2'h1, 8'h33);
    r(2'h1, 8'h03);
    r(2'h1, 8'h32);
    r(2'h1, 8'h03);
    w(2'h3, 8'hd8);
    t(3'h7);
    r(2'h1, 8'h31);
    r(2'h1, 8'h03);
    r(2'h2, 8'h22);
    r(2'h2, 8'h02);
  endtask : s_rback
  // Reprogramming drops a held status; one-byte format
  task automatic s_fmt();
    w(2'h3, 8'he8);
    w(2'h3, 8'h90);
    r(2'h2, 8'h21);
    t(3'h4);
    w(2'h3, 8'he8);
    r(2'h2, 8'h50);
    w(2'h2, 8'h05);
    t(3'h4);
    r(2'h2, 8'h05);
    r(2'h2, 8'h05);
    w(2'h3, 8'h8f);
    t(3'h4);
    r(2'h2, 8'h05);
    r(2'h2, 8'h04);
    repeat (4) t(3'h4);
    w(2'h3, 8'he8);
    r(2'h2, 8'h90);
    cbit(out_lvl[2], 1'b1);
    cbit(out_lvl[0], 1'b0);
    u_itc_host_model.rd(2'h3, rv, roe);
    cbit(roe, 1'b0);
    cb(rv, 8'h90);
  endtask : s_fmt
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Reset then scenarios
  initial begin
    rst_n_i = 1'b0;
    tick    = 3'h0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    s_latch();
    s_mix();
    s_rback();
    s_fmt();
    final_report();
  end
  // Hang guard: the run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end
endmodule : itc_top_bench
bind itc_top itc_asserts #(.NUM_CH(NUM_CH)) u_itc_asserts (.*);
`default_nettype wire
